/* File: pkg/sacc_pkg.sv */
// Package holding constants for the SAR converter conversion control block.
package sacc_pkg;

    // ==========================================================
    // Register map.
    localparam logic [1:0] ADDR_STATUS_CONTROL = 2'h0;
    localparam logic [1:0] ADDR_DATA = 2'h1;
    localparam logic [1:0] ADDR_CLOCK_CONFIG = 2'h2;

    // ==========================================================
    // Status/control bit positions.
    localparam int BIT_DONE = 7;
    localparam int BIT_IRQ_EN = 6;
    localparam int BIT_CONT = 5;
    localparam int CH_MSB = 4;
    // Clock config bit positions.
    localparam int PRESCALE_LSB = 5;
    localparam int BIT_CLK_SRC = 4;

    // ==========================================================
    // Channel codes.
    localparam logic [4:0] CH_LAST_PIN = 5'h07;
    localparam logic [4:0] CH_REF_HIGH = 5'h1D;
    localparam logic [4:0] CH_REF_LOW = 5'h1E;
    localparam logic [4:0] CH_POWER_OFF = 5'h1F;

    // ==========================================================
    // Reset values.
    localparam logic [7:0] RST_STATUS_CONTROL = 8'h1F;
    localparam logic [7:0] RST_CLOCK_CONFIG = 8'h00;
    localparam logic [7:0] RST_DATA = 8'h00;

    // ==========================================================
    // Timing in converter clock cycles: one sample cycle then eight bit
    // trials of two cycles each, giving 17 cycles from the start tick.
    localparam logic [4:0] CONV_CYCLES = 5'h11;
    localparam logic [4:0] SAMPLE_CYCLES = 5'h01;

    typedef enum logic [1:0] {
        SACC_IDLE,
        SACC_SAMPLE,
        SACC_TRIAL,
        SACC_DONE
    } sacc_state_e;

endpackage

/* File: logic/sacc_top.sv */
// Conversion control for an 8-bit successive-approximation converter.
//
// Decided for this implementation: the address-and-strobe port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
module sacc_top (
    input wire logic ref_clk,
    input wire logic nrst,
    input wire logic crystal_clock,
    input wire logic [1:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_write,
    input wire logic reg_read,
    output logic [7:0] reg_rdata,
    input wire logic stop_mode,
    input wire logic comparator_high,
    output logic [4:0] mux_select,
    output logic [7:0] dac_code,
    output logic sample_hold,
    output logic analog_power_on,
    output logic conv_irq,
    input wire logic [7:0] port_data_in,
    input wire logic [7:0] port_out,
    input wire logic [7:0] port_dir,
    output logic [7:0] pin_out,
    output logic [7:0] pin_oe,
    output logic [7:0] port_read_data
);

    // ==========================================================
    // Input synchronisers for pins, comparator, stop input and the crystal clock.
    logic [7:0] pin_meta;
    logic [7:0] pin_sync;
    logic cmp_meta;
    logic cmp_sync;
    logic xtal_meta;
    logic xtal_sync;
    logic xtal_prev;
    logic stop_meta;
    logic stop_sync;

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            pin_meta <= 8'h00;
            pin_sync <= 8'h00;
            cmp_meta <= 1'b0;
            cmp_sync <= 1'b0;
            xtal_meta <= 1'b0;
            xtal_sync <= 1'b0;
            xtal_prev <= 1'b0;
            stop_meta <= 1'b0;
            stop_sync <= 1'b0;
        end else begin
            pin_meta <= port_data_in;
            pin_sync <= pin_meta;
            cmp_meta <= comparator_high;
            cmp_sync <= cmp_meta;
            xtal_meta <= crystal_clock;
            xtal_sync <= xtal_meta;
            xtal_prev <= xtal_sync;
            stop_meta <= stop_mode;
            stop_sync <= stop_meta;
        end
    end

    // ==========================================================
    // Registers.
    logic irq_en;
    logic cont_mode;
    logic done_flag;
    logic [4:0] channel;
    logic [2:0] prescale;
    logic clk_src;
    logic [7:0] data_result;
    logic irq_pend;

    wire wr_sc = reg_write && (reg_addr == sacc_pkg::ADDR_STATUS_CONTROL);
    wire wr_clk = reg_write && (reg_addr == sacc_pkg::ADDR_CLOCK_CONFIG);
    wire rd_data = reg_read && (reg_addr == sacc_pkg::ADDR_DATA);
    // Channel code 31 powers the converter off.
    wire powered = (channel != sacc_pkg::CH_POWER_OFF);
    wire next_powered = wr_sc ? (reg_wdata[sacc_pkg::CH_MSB:0] != sacc_pkg::CH_POWER_OFF)
                              : powered;
    wire ch_is_pin = (channel <= sacc_pkg::CH_LAST_PIN);

    // ==========================================================
    // Converter clock tick: input source then prescaler.
    logic [3:0] div_cnt;
    // Source bit selects bus or crystal clock.
    wire src_edge = clk_src ? 1'b1 : (xtal_sync && !xtal_prev);

    function automatic logic [3:0] div_limit(input logic [2:0] code);
        if (code[2]) begin
            div_limit = 4'hF;
        end else begin
            div_limit = 4'(({3'h0, 1'b1} << code[1:0]) - 4'h1);
        end
    endfunction

    wire [3:0] next_div_limit = div_limit(prescale);
    wire conv_tick = src_edge && (div_cnt >= next_div_limit);
    wire [3:0] next_div_cnt = !src_edge ? div_cnt : (conv_tick ? 4'h0 : div_cnt + 4'h1);

    // ==========================================================
    // Successive approximation sequencer.
    sacc_pkg::sacc_state_e state;
    sacc_pkg::sacc_state_e next_state;
    logic [4:0] cyc_cnt;
    logic [2:0] bit_idx;
    logic [7:0] trial;
    logic [7:0] next_trial;
    logic finish;

    // Keep a tried bit when the input is above the trial level.
    wire [7:0] bit_mask = 8'(8'h01 << bit_idx);
    wire [7:0] kept = cmp_sync ? trial : (trial & ~bit_mask);
    wire trial_phase_end = cyc_cnt[0];

    always_comb begin
        next_state = state;
        next_trial = trial;
        finish = 1'b0;
        case (state)
            sacc_pkg::SACC_IDLE: begin
                // Continuous mode resumes once stop or power-off ends.
                next_state = cont_mode ? sacc_pkg::SACC_SAMPLE : sacc_pkg::SACC_IDLE;
            end
            sacc_pkg::SACC_SAMPLE: begin
                if (conv_tick) begin
                    next_state = sacc_pkg::SACC_TRIAL;
                    next_trial = 8'h80;
                end
            end
            sacc_pkg::SACC_TRIAL: begin
                if (conv_tick && trial_phase_end) begin
                    if (bit_idx == 3'h0) begin
                        next_trial = kept;
                        next_state = sacc_pkg::SACC_DONE;
                    end else begin
                        next_trial = kept | (bit_mask >> 1);
                    end
                end
            end
            sacc_pkg::SACC_DONE: begin
                finish = 1'b1;
                // Continuous mode restarts, single mode idles.
                next_state = cont_mode ? sacc_pkg::SACC_SAMPLE : sacc_pkg::SACC_IDLE;
            end
            default: begin
                next_state = sacc_pkg::SACC_IDLE;
            end
        endcase
    end

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            state <= sacc_pkg::SACC_IDLE;
            cyc_cnt <= 5'h00;
            bit_idx <= 3'h7;
            trial <= 8'h00;
            div_cnt <= 4'h0;
        end else if (stop_sync || !next_powered) begin
            // Stop or power-off aborts and holds the sequencer idle.
            state <= sacc_pkg::SACC_IDLE;
            cyc_cnt <= 5'h00;
            bit_idx <= 3'h7;
            trial <= 8'h00;
            div_cnt <= 4'h0;
        end else if (wr_sc) begin
            // Write starts; restart from first bit.
            state <= sacc_pkg::SACC_SAMPLE;
            cyc_cnt <= 5'h00;
            bit_idx <= 3'h7;
            trial <= 8'h00;
            div_cnt <= 4'h0;
        end else begin
            state <= next_state;
            trial <= next_trial;
            div_cnt <= next_div_cnt;
            if (next_state == sacc_pkg::SACC_SAMPLE && state != sacc_pkg::SACC_SAMPLE) begin
                cyc_cnt <= 5'h00;
                bit_idx <= 3'h7;
            end else if (conv_tick && state == sacc_pkg::SACC_TRIAL) begin
                cyc_cnt <= cyc_cnt + 5'h01;
                if (trial_phase_end) begin
                    bit_idx <= bit_idx - 3'h1;
                end
            end
        end
    end

    // ==========================================================
    // Register writes and completion flags.
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            // Reset clears enable, continuous and done.
            irq_en <= 1'b0;
            cont_mode <= 1'b0;
            channel <= sacc_pkg::RST_STATUS_CONTROL[sacc_pkg::CH_MSB:0];
            prescale <= sacc_pkg::RST_CLOCK_CONFIG[7:sacc_pkg::PRESCALE_LSB];
            clk_src <= sacc_pkg::RST_CLOCK_CONFIG[sacc_pkg::BIT_CLK_SRC];
            data_result <= sacc_pkg::RST_DATA;
            done_flag <= 1'b0;
            irq_pend <= 1'b0;
        end else begin
            if (wr_sc) begin
                irq_en <= reg_wdata[sacc_pkg::BIT_IRQ_EN];
                cont_mode <= reg_wdata[sacc_pkg::BIT_CONT];
                channel <= reg_wdata[sacc_pkg::CH_MSB:0];
            end
            if (wr_clk) begin
                prescale <= reg_wdata[7:sacc_pkg::PRESCALE_LSB];
                clk_src <= reg_wdata[sacc_pkg::BIT_CLK_SRC];
            end
            // Each result overwrites the data register.
            if (finish) begin
                data_result <= trial;
            end
            // Done sets on finish, clears on data read or status write; set wins.
            // Flag stays zero with interrupts enabled.
            if (irq_en) begin
                done_flag <= 1'b0;
            end else if (finish) begin
                done_flag <= 1'b1;
            end else if (rd_data || wr_sc) begin
                done_flag <= 1'b0;
            end
            // Interrupt per conversion; cleared by data read or status write.
            // Request is a plain level, so it works during wait.
            if (irq_en && finish) begin
                irq_pend <= 1'b1;
            end else if (rd_data || wr_sc || !irq_en) begin
                irq_pend <= 1'b0;
            end
        end
    end

    // ==========================================================
    // Read data, one cycle after the strobe.
    wire [7:0] sc_view = {done_flag, irq_en, cont_mode, channel};
    wire [7:0] clk_view = {prescale, clk_src, 4'h0};
    wire [7:0] next_rdata = (reg_addr == sacc_pkg::ADDR_STATUS_CONTROL) ? sc_view
                          : (reg_addr == sacc_pkg::ADDR_DATA) ? data_result
                          : (reg_addr == sacc_pkg::ADDR_CLOCK_CONFIG) ? clk_view
                          : 8'h00;

    // ==========================================================
    // Port pin takeover.
    // One-hot selection of the channel pin; all zero for channels above 7.
    wire [7:0] sel_onehot = ch_is_pin ? 8'(8'h01 << channel[2:0]) : 8'h00;
    // Selected pin is input, others follow the port.
    wire [7:0] next_pin_oe = port_dir & ~sel_onehot;
    wire [7:0] next_port_read = pin_sync & ~sel_onehot;

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            reg_rdata <= 8'h00;
            mux_select <= sacc_pkg::CH_POWER_OFF;
            dac_code <= 8'h00;
            sample_hold <= 1'b0;
            analog_power_on <= 1'b0;
            conv_irq <= 1'b0;
            pin_out <= 8'h00;
            pin_oe <= 8'h00;
            port_read_data <= 8'h00;
        end else begin
            reg_rdata <= reg_read ? next_rdata : 8'h00;
            mux_select <= channel;
            dac_code <= trial;
            sample_hold <= (state == sacc_pkg::SACC_SAMPLE);
            analog_power_on <= powered;
            conv_irq <= irq_pend;
            pin_out <= port_out & ~sel_onehot;
            pin_oe <= next_pin_oe;
            port_read_data <= next_port_read;
        end
    end

endmodule
`default_nettype wire

/* File: testbench/sacc_top_checker.sv */
// Concurrent checks on the ports of the conversion control block.
`timescale 1ns/1ps
`default_nettype none
module sacc_checker (
    input wire logic ref_clk,
    input wire logic nrst,
    input wire logic [1:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_write,
    input wire logic reg_read,
    input wire logic [7:0] reg_rdata,
    input wire logic stop_mode,
    input wire logic [4:0] mux_select,
    input wire logic sample_hold,
    input wire logic analog_power_on,
    input wire logic conv_irq,
    input wire logic [7:0] port_dir,
    input wire logic [7:0] pin_oe,
    input wire logic [7:0] port_read_data
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!nrst);

    // ==========================================================
    // Conversion start, completion and reset.
    property p_start;
        reg_write && reg_addr == 2'h0 && reg_wdata[4:0] <= 5'h07 && !stop_mode
            |=> ##[0:2] sample_hold;
    endproperty
    a_start: assert property (p_start) else $error("no sampling after start");
    property p_irq_clear;
        reg_write && reg_addr == 2'h0 |=> ##1 !conv_irq [*2];
    endproperty
    a_irq_clear: assert property (p_irq_clear) else $error("request kept after write");
    property p_no_flag;
        reg_read && reg_addr == 2'h0 |=> !(reg_rdata[6] && reg_rdata[7]);
    endproperty
    a_no_flag: assert property (p_no_flag) else $error("flag set with irq on");
    property p_stop;
        stop_mode [*6] |-> !sample_hold && !$rose(conv_irq);
    endproperty
    a_stop: assert property (p_stop) else $error("active in stop");
    property p_reset;
        $rose(nrst) |-> mux_select == 5'h1F && !conv_irq && !sample_hold;
    endproperty
    a_reset: assert property (p_reset) else $error("bad state after reset");

    // ==========================================================
    // Pin takeover and power.
    property p_pin_input;
        mux_select <= 5'h07 && $stable(mux_select) |-> !pin_oe[mux_select[2:0]];
    endproperty
    a_pin_input: assert property (p_pin_input) else $error("selected pin driven");
    property p_pin_read;
        mux_select <= 5'h07 && $stable(mux_select) |-> !port_read_data[mux_select[2:0]];
    endproperty
    a_pin_read: assert property (p_pin_read) else $error("selected pin reads one");
    property p_free_pins;
        $past(nrst) && mux_select == 5'h1F && $past(mux_select) == 5'h1F
            |-> pin_oe == $past(port_dir);
    endproperty
    a_free_pins: assert property (p_free_pins) else $error("port enable lost");
    property p_power;
        mux_select == 5'h1F |-> !analog_power_on;
    endproperty
    a_power: assert property (p_power) else $error("powered while off");
endmodule
bind sacc_top sacc_checker u_chk (.*);
`default_nettype wire

/* File: testbench/sacc_analog_model.sv */
// Behavioural analog inputs and comparator facing the converter.
`timescale 1ns/1ps
`default_nettype none
module sacc_analog_model (
    input wire logic ref_clk,
    input wire logic [4:0] mux_select,
    input wire logic [7:0] dac_code,
    input wire logic sample_hold,
    input wire logic [63:0] ch_levels,
    output logic comparator_high
);
    logic [7:0] held;
    logic [7:0] level;
    assign level = mux_select == 5'h1D ? 8'hFF : mux_select == 5'h1E ? 8'h00 :
                   mux_select <= 5'h07 ? ch_levels[mux_select[2:0] * 8 +: 8] : 8'hA5;
    always_ff @(posedge ref_clk) begin
        if (sample_hold) begin
            held <= level;
        end
    end
    assign comparator_high = held >= dac_code;
endmodule
`default_nettype wire

/* File: testbench/tb_sacc_top.sv */
// Self-checking testbench for the converter control block.
`timescale 1ns/1ps
`default_nettype none
module tb_sacc_top;
    logic ref_clk, nrst, crystal_clock, reg_write, reg_read, stop_mode, comparator_high;
    logic [1:0] reg_addr;
    logic [7:0] reg_wdata, reg_rdata, dac_code, pin_out, pin_oe, port_read_data;
    logic [7:0] port_out, port_dir, port_data_in;
    logic [4:0] mux_select;
    logic sample_hold, analog_power_on, conv_irq;
    logic [63:0] ch_levels;
    int n_mismatch, checks;
    sacc_top u_dut (.*);
    sacc_analog_model u_model (.*);
    initial begin
        ref_clk = 1'b0;
        forever #12.5 ref_clk = ~ref_clk;
    end
    initial begin
        crystal_clock = 1'b0;
        #7;
        forever #100 crystal_clock = ~crystal_clock;
    end
    task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
        checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("MISMATCH %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic wr(input logic [1:0] a, input logic [7:0] d);
        reg_addr <= a;
        reg_wdata <= d;
        reg_write <= 1'b1;
        @(posedge ref_clk);
        reg_write <= 1'b0;
    endtask
    task automatic rd(input logic [1:0] a, input logic [7:0] exp, input string name);
        reg_addr <= a;
        reg_read <= 1'b1;
        @(posedge ref_clk);
        reg_read <= 1'b0;
        @(negedge ref_clk);
        chk(name, reg_rdata, exp);
        @(posedge ref_clk);
    endtask
    task automatic idle(input int n);
        repeat (n) @(posedge ref_clk);
    endtask
    task automatic conv(input logic [7:0] sc, output int cyc);
        wr(2'h0, sc);
        cyc = 0;
        while (conv_irq !== 1'b1 && cyc < 400) begin
            @(posedge ref_clk);
            cyc++;
        end
        if (cyc >= 400) begin
            n_mismatch++;
        end
    endtask
    task automatic t_reset();
        rd(2'h0, 8'h1F, "status");
        rd(2'h2, 8'h00, "clock_config");
        wr(2'h1, 8'h55);
        rd(2'h1, 8'h00, "result");
        rd(2'h3, 8'h00, "unmapped");
    endtask
    task automatic t_channels();
        int c;
        logic [4:0] ch;
        wr(2'h2, 8'h30);
        for (int i = 0; i < 10; i++) begin
            ch = (i < 8) ? 5'(i) : 5'(i + 21);
            conv({3'b010, ch}, c);
            rd(2'h0, {3'b010, ch}, "status");
            chk("irq", {7'h00, conv_irq}, 8'h01);
            rd(2'h1, i < 8 ? ch_levels[i * 8 +: 8] : (i == 8 ? 8'hFF : 8'h00), "result");
            idle(1);
            chk("irq", {7'h00, conv_irq}, 8'h00);
        end
        conv(8'h43, c);
        wr(2'h0, 8'h03);
        idle(2);
        chk("irq_write", {7'h00, conv_irq}, 8'h00);
    endtask
    task automatic t_prescale();
        logic [7:0] cfg [7] = '{8'h30, 8'h50, 8'h70, 8'h90, 8'hF0, 8'h00, 8'h20};
        int per [7] = '{2, 4, 8, 16, 16, 8, 16};
        int c;
        for (int i = 0; i < 7; i++) begin
            wr(2'h2, cfg[i]);
            conv(8'h43, c);
            chk("time", 8'((c >= 16 * per[i]) && (c <= 18 * per[i] + 8)), 8'h01);
            rd(2'h1, ch_levels[31:24], "result");
        end
        wr(2'h2, 8'h30);
        wr(2'h0, 8'h40);
        idle(5);
        conv(8'h44, c);
        chk("restart", 8'(c >= 34), 8'h01);
        rd(2'h1, ch_levels[39:32], "result");
    endtask
    task automatic t_single_cont();
        wr(2'h0, 8'h02);
        idle(40);
        rd(2'h0, 8'h82, "status");
        rd(2'h1, ch_levels[23:16], "result");
        rd(2'h0, 8'h02, "status");
        idle(40);
        rd(2'h0, 8'h02, "status");
        wr(2'h0, 8'h21);
        idle(45);
        ch_levels[15:8] <= 8'hC3;
        idle(80);
        rd(2'h0, 8'hA1, "status");
        rd(2'h1, 8'hC3, "result");
        idle(45);
        rd(2'h0, 8'hA1, "status");
        wr(2'h0, 8'h01);
        idle(40);
        rd(2'h1, 8'hC3, "result");
    endtask
    task automatic t_pins_stop();
        port_dir <= 8'hFF;
        port_out <= 8'hFF;
        port_data_in <= 8'hFF;
        wr(2'h0, 8'h05);
        idle(6);
        chk("pin_oe", pin_oe, 8'hDF);
        chk("pin_out", pin_out, 8'hDF);
        chk("port_read", port_read_data, 8'hDF);
        port_out <= 8'h0F;
        idle(30);
        chk("pin_out", pin_out, 8'h0F);
        rd(2'h1, ch_levels[47:40], "result");
        wr(2'h0, 8'h26);
        idle(3);
        stop_mode <= 1'b1;
        idle(60);
        rd(2'h0, 8'h26, "status");
        stop_mode <= 1'b0;
        idle(60);
        rd(2'h0, 8'hA6, "status");
        wr(2'h0, 8'h1F);
        idle(40);
        rd(2'h1, ch_levels[55:48], "result");
        rd(2'h0, 8'h1F, "status");
        chk("power", {7'h00, analog_power_on}, 8'h00);
    endtask
    task automatic end_of_test();
        $display("Checks %0d mismatches %0d", checks, n_mismatch);
        if (n_mismatch == 0 && checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    initial begin
        nrst = 1'b0;
        reg_addr = 2'h0;
        reg_wdata = 8'h00;
        reg_write = 1'b0;
        reg_read = 1'b0;
        stop_mode = 1'b0;
        port_out = 8'h00;
        port_dir = 8'h00;
        port_data_in = 8'h00;
        ch_levels = 64'h7E6D_5C4B_3A29_1807;
        n_mismatch = 0;
        checks = 0;
        repeat (4) @(posedge ref_clk);
        nrst <= 1'b1;
        @(posedge ref_clk);
        t_reset();
        t_channels();
        t_prescale();
        t_single_cont();
        t_pins_stop();
        end_of_test();
    end
    initial begin
        #(25 * 20000);
        n_mismatch++;
        end_of_test();
    end
endmodule
`default_nettype wire
